/* File: epc_pkg.sv */
// constants, types and field layout for the eeprom guard and power control block
//
// Summary of operation
// RL1: status2 bit0 set: deep sleep after write
// RL2: status2 bit1 set: throttle oscillator while writing
// RL3: status2 bits 7..2 always read zero
// RL4: short write frame at chip select rise discarded
// RL5: status1 locked only when lock set, guard low
// RL6: writes ignored unless write latch previously set
// RL7: guard pair selects none, quarter, half, all
// RL8: idle with chip select high means standby
// RL9: sleep accepts only the wake command
// RL10: deep sleep ignores every command
// RL11: deep sleep flag reads one via pull-up
// RL12: only exit sequence leaves deep sleep
// RL13: status2 write never triggers automatic deep sleep
// RL14: auto sleep idles asleep, wakes on select
// RL15: master clears auto sleep before clock change
// RL16: sleep command under auto sleep needs wake
// RL17: low power idle left on select fall
// RL18: master clears low power idle before clock change
// RL19: sleep command under low power idle needs wake
// RL20: status2 write needs latch, busy, then clears both
// RL21: lock clears only while guard pin high
// RL22: guarded program or erase silently dropped
// RL23: status2 bits reset to zero
package epc_pkg;

	// timing
	localparam int CLK_PERIOD_NS   = 25;
	localparam int WRITE_TIME_NS   = 5000;
	localparam int WRITE_CYCLES    = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int THROTTLE_PERIOD = 4;
	localparam logic [9:0] BUSY_LOAD = 10'(WRITE_CYCLES);

	// opcodes
	localparam logic [7:0] OP_STATUS1_WRITE = 8'h01;
	localparam logic [7:0] OP_PROGRAM       = 8'h02;
	localparam logic [7:0] OP_CLEAR_LATCH   = 8'h04;
	localparam logic [7:0] OP_STATUS1_READ  = 8'h05;
	localparam logic [7:0] OP_SET_LATCH     = 8'h06;
	localparam logic [7:0] OP_STATUS2_WRITE = 8'h31;
	localparam logic [7:0] OP_STATUS2_READ  = 8'h35;
	localparam logic [7:0] OP_PAGE_ERASE    = 8'h42;
	localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
	localparam logic [7:0] OP_DEEP_SLEEP    = 8'h79;
	localparam logic [7:0] OP_SLEEP         = 8'hB9;
	localparam logic [7:0] OP_WAKE          = 8'hAB;

	// frame lengths in serial clock cycles
	localparam logic [8:0] LEN_OP       = 9'h008;
	localparam logic [8:0] LEN_OP_DATA  = 9'h010;
	localparam logic [8:0] LEN_OP_ADDR  = 9'h018;
	localparam logic [8:0] LEN_FULL     = 9'h020;
	localparam logic [8:0] LEN_MAX      = 9'h1FF;

	// status byte 1 fields
	localparam int S1_BUSY  = 0;
	localparam int S1_LATCH = 1;
	localparam int S1_BGL   = 2;
	localparam int S1_BGH   = 3;
	localparam int S1_DEEP  = 4;
	localparam int S1_LPI   = 5;
	localparam int S1_AUTO  = 6;
	localparam int S1_LOCK  = 7;
	localparam logic [7:0] S1_NV_RESET = 8'h00;

	// status byte 2 fields
	localparam int S2_ADS = 0;
	localparam int S2_THR = 1;
	localparam logic [1:0] S2_RESET = 2'h0;

	// guarded address ranges
	localparam logic [15:0] GUARD_QTR_BASE  = 16'h6000;
	localparam logic [15:0] GUARD_HALF_BASE = 16'h4000;
	localparam logic [15:0] GUARD_ALL_BASE  = 16'h0000;
	localparam logic [15:0] GUARD_TOP       = 16'h7FFF;

	typedef enum logic [2:0] {
		PWR_STANDBY,
		PWR_LOW_IDLE,
		PWR_AUTO_SLEEP,
		PWR_ACTIVE,
		PWR_SLEEP,
		PWR_DEEP_SLEEP
	} epc_power_t;

	// synchronised pin group
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic sdi;
		logic guard_n;
		logic deep_exit;
	} epc_pins_t;

	// nonvolatile and volatile configuration
	typedef struct packed {
		logic       status_lock_bit;
		logic       auto_sleep_enable;
		logic       low_power_idle_enable;
		logic       block_guard_high;
		logic       block_guard_low;
	} epc_status1_t;

endpackage : epc_pkg

/* File: epc_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module epc_sync
	import epc_pkg::*;
(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rst,
	// pins and synchronised copy
	input  wire epc_pins_t pins,
	output var  epc_pins_t pins_sync
);

	epc_pins_t stage1;

	// stage1 feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1    <= '{cs_n: 1'b1, guard_n: 1'b1, default: 1'b0};
			pins_sync <= '{cs_n: 1'b1, guard_n: 1'b1, default: 1'b0};
		end else begin
			stage1    <= pins;
			pins_sync <= stage1;
		end
	end

endmodule : epc_sync
`default_nettype wire

/* File: epc_guard_power.sv */
// serial eeprom write protection and power mode controller
`timescale 1ns/100ps
`default_nettype none
module epc_guard_power
	import epc_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	// serial link
	input  wire logic        CS_N,
	input  wire logic        SCK,
	input  wire logic        SDI,
	output var  logic        SDO_O,
	output var  logic        SDO_OE_N,
	// protection and wake pins
	input  wire logic        GUARD_N,
	input  wire logic        DEEP_EXIT,
	// array requests
	output var  logic        MEM_PROG,
	output var  logic        MEM_ERASE,
	output var  logic        MEM_CHIP,
	output var  logic [15:0] MEM_ADDR,
	output var  logic [7:0]  MEM_DATA,
	// power status
	output var  logic        OSC_SLOW,
	output var  epc_power_t  PWR_STATE
);

	epc_pins_t    pins_in;
	epc_pins_t    s;
	epc_status1_t st1;
	epc_power_t   pstate;
	epc_power_t   next_pstate;
	logic         sck_d;
	logic         cs_d;
	logic         exit_d;
	logic [8:0]   bitcnt;
	logic [31:0]  frame;
	logic [7:0]   op;
	logic         live;
	logic         write_enable_latch;
	logic         write_in_progress;
	logic         eligible;
	logic [1:0]   s2;
	logic [9:0]   busy_cnt;
	logic [1:0]   thr_cnt;

	assign pins_in = '{cs_n: CS_N, sck: SCK, sdi: SDI, guard_n: GUARD_N, deep_exit: DEEP_EXIT};

	epc_sync u_sync (
		.clk       (CLK),
		.rst       (SYS_RST),
		.pins      (pins_in),
		.pins_sync (s)
	);

	// edges of the sampled link
	wire sck_rise  = s.sck & ~sck_d;
	wire sck_fall  = ~s.sck & sck_d;
	wire cs_fall   = ~s.cs_n & cs_d;
	wire cs_rise   = s.cs_n & ~cs_d;
	wire exit_rise = s.deep_exit & ~exit_d;
	wire in_deep   = (pstate == PWR_DEEP_SLEEP);
	wire in_sleep  = (pstate == PWR_SLEEP);

	// frame field decode
	wire [15:0] f_addr24 = frame[15:0];
	wire [15:0] f_addr32 = frame[23:8];
	wire [7:0]  f_data16 = frame[7:0];
	wire [7:0]  f_data32 = frame[7:0];
	wire        len_op   = (bitcnt == LEN_OP);
	wire        len_dat  = (bitcnt == LEN_OP_DATA);
	wire        len_adr  = (bitcnt == LEN_OP_ADDR);
	wire        len_full = (bitcnt >= LEN_FULL) && (bitcnt[2:0] == 3'h0);

	// guarded window from the guard pair
	wire [1:0]  bp = {st1.block_guard_high, st1.block_guard_low};
	function automatic logic in_guard(input logic [1:0] sel, input logic [15:0] a);
		logic [15:0] base;
		base = (sel == 2'h1) ? GUARD_QTR_BASE :
		       (sel == 2'h2) ? GUARD_HALF_BASE : GUARD_ALL_BASE;
		in_guard = (sel != 2'h0) && (a >= base) && (a <= GUARD_TOP); // see RL7
	endfunction : in_guard

	wire guard_prog  = in_guard(bp, f_addr32);
	wire guard_erase = in_guard(bp, f_addr24);
	wire s1_locked   = st1.status_lock_bit & ~s.guard_n; // see RL5 see RL21

	// command execution strobes at chip select rise
	wire exec      = cs_rise & live & ~in_deep; // see RL10
	wire can_write = exec & ~in_sleep & ~write_in_progress & write_enable_latch; // see RL6
	wire ex_set    = exec & ~in_sleep & len_op & (op == OP_SET_LATCH);
	wire ex_clr    = exec & ~in_sleep & len_op & (op == OP_CLEAR_LATCH);
	wire ex_sleep  = exec & ~in_sleep & len_op & (op == OP_SLEEP);
	wire ex_deep   = exec & ~in_sleep & len_op & (op == OP_DEEP_SLEEP);
	wire ex_wake   = exec & in_sleep & len_op & (op == OP_WAKE); // see RL9
	wire ex_s1     = can_write & len_dat & (op == OP_STATUS1_WRITE); // see RL4
	wire ex_s1_ok  = ex_s1 & ~s1_locked; // see RL5
	wire ex_s2     = can_write & len_dat & (op == OP_STATUS2_WRITE); // see RL4 see RL20
	wire ex_prog   = can_write & len_full & (op == OP_PROGRAM);
	wire ex_page   = can_write & len_adr & (op == OP_PAGE_ERASE);
	wire ex_chip   = can_write & len_op & ((op == OP_CHIP_ERASE_A) | (op == OP_CHIP_ERASE_B));
	wire go_prog   = ex_prog & ~guard_prog; // see RL22
	wire go_page   = ex_page & ~guard_erase; // see RL22
	wire go_chip   = ex_chip & (bp == 2'h0); // see RL22
	wire start_wr  = ex_s1_ok | ex_s2 | go_prog | go_page | go_chip;
	wire dropped   = (ex_s1 & s1_locked) | (ex_prog & guard_prog) | (ex_page & guard_erase) |
	                 (ex_chip & (bp != 2'h0));

	// throttled timer tick, slowed only when asked
	wire thr_on    = s2[S2_THR];
	wire tick      = ~thr_on | (thr_cnt == 2'h0); // see RL2
	wire busy_done = write_in_progress & tick & (busy_cnt == 10'h001);
	wire auto_deep = busy_done & eligible & s2[S2_ADS]; // see RL1 see RL13

	// read data for the two status bytes
	wire [7:0] rd_s1 = {st1.status_lock_bit, st1.auto_sleep_enable, st1.low_power_idle_enable,
	                    in_deep, st1.block_guard_high, st1.block_guard_low,
	                    write_enable_latch, write_in_progress}; // see RL11
	wire [7:0] rd_s2 = {6'h00, s2}; // see RL3
	wire [7:0] rd_byte = (op == OP_STATUS2_READ) ? rd_s2 : rd_s1;
	wire       reading = live & ~s.cs_n & ~in_sleep & ~in_deep & (bitcnt >= LEN_OP) &
	                     ((op == OP_STATUS1_READ) | (op == OP_STATUS2_READ));

	// power mode selection
	always_comb begin
		next_pstate = pstate;
		unique case (pstate)
			PWR_DEEP_SLEEP: begin
				if (exit_rise)
					next_pstate = PWR_STANDBY; // see RL12
			end
			PWR_SLEEP: begin
				if (ex_wake)
					next_pstate = PWR_STANDBY; // see RL9 see RL16 see RL19
			end
			PWR_STANDBY, PWR_LOW_IDLE, PWR_AUTO_SLEEP, PWR_ACTIVE: begin
				if (ex_deep | auto_deep)
					next_pstate = PWR_DEEP_SLEEP;
				else if (ex_sleep)
					next_pstate = PWR_SLEEP;
				else if (write_in_progress | start_wr | ~s.cs_n)
					next_pstate = PWR_ACTIVE; // see RL14 see RL17
				else if (st1.auto_sleep_enable)
					next_pstate = PWR_AUTO_SLEEP; // see RL14
				else if (st1.low_power_idle_enable)
					next_pstate = PWR_LOW_IDLE; // see RL17
				else
					next_pstate = PWR_STANDBY; // see RL8
			end
		endcase
	end

	// link edge history
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sck_d  <= 1'b0;
			cs_d   <= 1'b1;
			exit_d <= 1'b0;
		end else begin
			sck_d  <= s.sck;
			cs_d   <= s.cs_n;
			exit_d <= s.deep_exit;
		end
	end

	// frame capture; deep sleep never opens a frame
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			live   <= 1'b0;
			bitcnt <= 9'h000;
			frame  <= 32'h0000_0000;
			op     <= 8'h00;
		end else if (cs_fall) begin
			live   <= ~in_deep; // see RL10
			bitcnt <= 9'h000;
			op     <= 8'h00;
		end else if (cs_rise) begin
			live   <= 1'b0;
		end else if (sck_rise & ~s.cs_n & live) begin
			if (bitcnt != LEN_MAX)
				bitcnt <= bitcnt + 9'h001;
			if (bitcnt < LEN_FULL)
				frame <= {frame[30:0], s.sdi};
			if (bitcnt == (LEN_OP - 9'h001))
				op <= {frame[6:0], s.sdi};
		end
	end

	// serial output, shifted on falling clock edges; undriven pin idles high by pull-up
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			SDO_O    <= 1'b1;
			SDO_OE_N <= 1'b1;
		end else if (~reading) begin
			SDO_O    <= 1'b1; // see RL11
			SDO_OE_N <= 1'b1;
		end else if (sck_fall) begin
			SDO_O    <= rd_byte[3'h7 - bitcnt[2:0]];
			SDO_OE_N <= 1'b0;
		end
	end

	// status byte 1 and the write latch
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st1                <= epc_status1_t'({S1_NV_RESET[S1_LOCK], S1_NV_RESET[S1_AUTO],
			                      S1_NV_RESET[S1_LPI], S1_NV_RESET[S1_BGH], S1_NV_RESET[S1_BGL]});
			write_enable_latch <= 1'b0;
		end else begin
			if (ex_s1_ok)
				st1 <= epc_status1_t'({f_data16[S1_LOCK], f_data16[S1_AUTO], f_data16[S1_LPI],
				                      f_data16[S1_BGH], f_data16[S1_BGL]}); // see RL5
			if (ex_set)
				write_enable_latch <= 1'b1;
			else if (ex_clr | ex_sleep | dropped | busy_done)
				write_enable_latch <= 1'b0; // see RL20
		end
	end

	// volatile status byte 2, cleared at power up
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			s2 <= S2_RESET; // see RL23
		else if (ex_s2)
			s2 <= {f_data16[S2_THR], f_data16[S2_ADS]}; // see RL20
	end

	// self-timed write timer
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			write_in_progress <= 1'b0;
			eligible          <= 1'b0;
			busy_cnt          <= 10'h000;
			thr_cnt           <= 2'h0;
		end else if (start_wr) begin
			write_in_progress <= 1'b1; // see RL20
			eligible          <= ~ex_s2; // see RL13
			busy_cnt          <= BUSY_LOAD;
			thr_cnt           <= 2'h0;
		end else if (write_in_progress) begin
			thr_cnt <= (thr_cnt == 2'(THROTTLE_PERIOD - 1)) ? 2'h0 : thr_cnt + 2'h1;
			if (busy_done)
				write_in_progress <= 1'b0; // see RL20
			if (tick)
				busy_cnt <= busy_cnt - 10'h001;
		end
	end

	// array request strobes and power outputs
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			MEM_PROG  <= 1'b0;
			MEM_ERASE <= 1'b0;
			MEM_CHIP  <= 1'b0;
			MEM_ADDR  <= 16'h0000;
			MEM_DATA  <= 8'h00;
			OSC_SLOW  <= 1'b0;
			pstate    <= PWR_STANDBY;
			PWR_STATE <= PWR_STANDBY;
		end else begin
			MEM_PROG  <= go_prog;
			MEM_ERASE <= go_page;
			MEM_CHIP  <= go_chip;
			if (go_prog | go_page)
				MEM_ADDR <= go_prog ? f_addr32 : f_addr24;
			if (go_prog)
				MEM_DATA <= f_data32;
			OSC_SLOW  <= write_in_progress & thr_on & ~tick; // see RL2
			pstate    <= next_pstate;
			PWR_STATE <= next_pstate;
		end
	end

	// checks
	localparam int BUSY_LIMIT = 900;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_write_begin;
		$rose(write_in_progress);
	endsequence

	sequence s_write_finish;
		##[1:BUSY_LIMIT] $fell(write_in_progress);
	endsequence

	chk_busy_bounded: assert property (s_write_begin |-> s_write_finish) // see RL20
		else $error("write in progress never ended");
	chk_latch_before_write: assert property ($rose(write_in_progress) // see RL6
		|-> $past(write_enable_latch))
		else $error("write started without latch");
	chk_latch_cleared_end: assert property ($fell(write_in_progress) // see RL20
		&& !$past(ex_set) |-> !write_enable_latch)
		else $error("latch left set after write");
	chk_lock_blocks_s1: assert property (ex_s1 && s1_locked |=> $stable(st1)) // see RL5
		else $error("locked status byte changed");
	chk_auto_deep_entry: assert property ($fell(write_in_progress) && $past(eligible && s2[S2_ADS])
		|-> pstate == PWR_DEEP_SLEEP) // see RL1
		else $error("no deep sleep after write");
	chk_s2_no_deep: assert property ($fell(write_in_progress) && !$past(eligible) && !$past(ex_deep)
		|-> pstate != PWR_DEEP_SLEEP) // see RL13
		else $error("status2 write caused deep sleep");
	chk_deep_holds: assert property (in_deep && !exit_rise |=> in_deep) // see RL12
		else $error("deep sleep left without exit");
	chk_sleep_wake_only: assert property (in_sleep && !ex_wake |=> in_sleep && !MEM_PROG) // see RL9
		else $error("sleep left without wake");
	chk_guard_drop: assert property (ex_prog && guard_prog |=> !MEM_PROG) // see RL22
		else $error("guarded program issued");
	chk_s2_reserved: assert property (reading && op == OP_STATUS2_READ // see RL3
		|-> rd_byte[7:2] == 6'h00)
		else $error("reserved bits nonzero");
	chk_short_s2: assert property (exec && op == OP_STATUS2_WRITE // see RL4
		&& !len_dat |=> $stable(s2))
		else $error("short frame wrote status2");

	// power mode steps: an idle state or a sleep seen with select low
	sequence s_idle_selected;
		(pstate == PWR_AUTO_SLEEP || pstate == PWR_LOW_IDLE) && !s.cs_n;
	endsequence

	sequence s_asleep_selected;
		in_sleep && !s.cs_n;
	endsequence

	// an idle state gives way to normal service once select falls
	chk_idle_wakes: assert property (s_idle_selected |=> pstate == PWR_ACTIVE) // see RL14 RL17
		else $error("idle state kept after select fall");

	// an explicit sleep outlives select falls, whatever the idle option
	chk_sleep_no_select: assert property (s_asleep_selected |=> in_sleep) // see RL16 RL19
		else $error("sleep left on select fall");

	// full rate timer whenever throttling is off
	chk_osc_full_rate: assert property (!thr_on |=> !OSC_SLOW) // see RL2
		else $error("oscillator slowed while throttle off");

	// deep sleep never drives the data pin, so the pull-up shows the flag
	chk_deep_undriven: assert property (in_deep |=> SDO_OE_N && SDO_O) // see RL11
		else $error("data pin driven in deep sleep");

	// a select fall in deep sleep must not open a frame
	chk_deep_no_frame: assert property (in_deep && cs_fall |=> !live) // see RL10
		else $error("frame opened in deep sleep");

endmodule : epc_guard_power
`default_nettype wire

/* File: epc_spi_master.sv */
// serial link master model for the guard and power controller bench
`timescale 1ns/100ps
`default_nettype none
module epc_spi_master
	import epc_pkg::*;
#(
	parameter int HALF_CLKS = 4
)
(
	// pacing clock
	input  wire logic clk,
	// serial link
	output var  logic cs_n,
	output var  logic sck,
	output var  logic sdi,
	input  wire logic sdo_o,
	input  wire logic sdo_oe_n
);
	// undriven data line floats up through the pull-up
	wire logic sdo = sdo_oe_n ? 1'b1 : sdo_o;

	// idle link: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		sdi  = 1'b0;
	end

	// one frame, msb first; half period never changes mid-run
	task automatic frame(input logic [39:0] bits, input int n, output logic [7:0] rd);
		rd = 8'h00;
		@(negedge clk) cs_n = 1'b0;
		repeat (HALF_CLKS) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			sdi = bits[39 - i];
			repeat (HALF_CLKS) @(negedge clk);
			sck = 1'b1;
			rd = {rd[6:0], sdo};
			repeat (HALF_CLKS) @(negedge clk);
			sck = 1'b0;
		end
		repeat (HALF_CLKS) @(negedge clk);
		cs_n = 1'b1;
		sdi = ~sdi; // released line shows no stale value
		repeat (8) @(negedge clk);
	endtask : frame
endmodule : epc_spi_master
`default_nettype wire

/* File: epc_guard_power_tb_top.sv */
// self-checking bench for the eeprom guard and power controller
`timescale 1ns/100ps
`default_nettype none
module epc_guard_power_tb_top
	import epc_pkg::*;
;
	typedef struct packed {
		logic [1:0]  bp;
		logic [7:0]  cmd;
		logic [15:0] addr;
		logic        ok;
	} epc_row_t;

	logic             clk = 1'b0;
	logic             sys_rst = 1'b1;
	logic             guard_n = 1'b1;
	logic             deep_exit = 1'b0;
	wire logic        cs_n, sck, sdi, sdo_o, sdo_oe_n;
	wire logic        mem_prog, mem_erase, mem_chip, osc_slow;
	wire logic [15:0] mem_addr;
	wire logic [7:0]  mem_data;
	wire epc_power_t  pwr_state;
	logic [7:0]       rd;
	logic             osc_seen = 1'b0;
	int               err_total = 0;
	int               total_checks = 0;
	int               n_req = 0;
	int               n0 = 0;
	int               cycles = 0;
	logic [7:0]       cfg [3] = '{8'h00, 8'h40, 8'h20};
	epc_power_t       idle [3] = '{PWR_STANDBY, PWR_AUTO_SLEEP, PWR_LOW_IDLE};
	// guard pair, request, target, accepted
	epc_row_t         rows [8] = '{
		'{2'b00, OP_PROGRAM, 16'h7FFF, 1'b1},
		'{2'b01, OP_PROGRAM, 16'h5FFF, 1'b1},
		'{2'b01, OP_PROGRAM, 16'h6000, 1'b0},
		'{2'b10, OP_PAGE_ERASE, 16'h3FFF, 1'b1},
		'{2'b10, OP_PAGE_ERASE, 16'h4000, 1'b0},
		'{2'b11, OP_PROGRAM, 16'h0000, 1'b0},
		'{2'b00, OP_CHIP_ERASE_A, 16'h0000, 1'b1},
		'{2'b01, OP_CHIP_ERASE_B, 16'h0000, 1'b0}
	};

	always #12.5 clk = ~clk;

	epc_guard_power i_epc_guard_power (
		.CLK(clk), .SYS_RST(sys_rst), .CS_N(cs_n), .SCK(sck), .SDI(sdi),
		.SDO_O(sdo_o), .SDO_OE_N(sdo_oe_n), .GUARD_N(guard_n), .DEEP_EXIT(deep_exit),
		.MEM_PROG(mem_prog), .MEM_ERASE(mem_erase), .MEM_CHIP(mem_chip),
		.MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .OSC_SLOW(osc_slow), .PWR_STATE(pwr_state)
	);

	epc_spi_master i_epc_spi_master (
		.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n)
	);

	// count array requests and throttle mid-cycle, away from the launching edge
	always @(negedge clk) begin
		n_req <= n_req + int'(mem_prog) + int'(mem_erase) + int'(mem_chip);
		if (osc_slow === 1'b1) osc_seen <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			err_total = err_total + 1;
			summarize();
		end
	end

	task automatic summarize;
		if (err_total == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// bus helpers: raw frame, status reads, latch set, timed writes
	task automatic xfer(input logic [39:0] bits, input int n);
		i_epc_spi_master.frame(bits, n, rd);
	endtask : xfer
	task automatic rd_is(input string name, input logic [7:0] exp);
		check(name, {8'h00, rd}, {8'h00, exp});
	endtask : rd_is
	task automatic rd1;
		xfer({OP_STATUS1_READ, 32'h0}, 16);
	endtask : rd1
	task automatic set_write_latch_cmd;
		xfer({OP_SET_LATCH, 32'h0}, 8);
	endtask : set_write_latch_cmd
	task automatic pwr(input string name, input epc_power_t e);
		check(name, 16'(pwr_state), 16'(e));
	endtask : pwr
	task automatic wait_idle;
		int k;
		k = 0;
		rd1();
		while (rd[S1_BUSY] !== 1'b0 && k < 60) begin
			rd1();
			k++;
		end
		check("busy_wait", 16'(k == 60), 16'h0);
	endtask : wait_idle
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		set_write_latch_cmd();
		xfer({o, d, 24'h0}, 16);
		wait_idle();
	endtask : wr

	// main sequence
	initial begin
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		pwr("pwr_reset", PWR_STANDBY);
		check("mem_reset", {13'h0, mem_prog, mem_erase, mem_chip}, 16'h0);
		xfer({OP_STATUS2_READ, 32'h0}, 16);
		rd_is("s2_reset", 8'h00);
		rd1();
		rd_is("s1_reset", 8'h00);
		// no latch: program and status2 write both ignored
		xfer({OP_PROGRAM, 16'h0010, 16'h3C00}, 32);
		xfer({OP_STATUS2_WRITE, 8'h03, 24'h0}, 16);
		xfer({OP_STATUS2_READ, 32'h0}, 16);
		rd_is("s2_no_latch", 8'h00);
		check("req_no_latch", 16'(n_req), 16'h0);
		// frame one bit short is dropped and keeps the latch
		set_write_latch_cmd();
		xfer({OP_PROGRAM, 16'h0010, 16'h3C00}, 31);
		check("req_short", 16'(n_req), 16'h0);
		xfer({OP_STATUS2_WRITE, 8'h03, 24'h0}, 15);
		xfer({OP_STATUS2_READ, 32'h0}, 16);
		rd_is("s2_short", 8'h00);
		rd1();
		rd_is("latch_kept", 8'h02);
		// guard pair table, guard pin low with lock clear
		guard_n = 1'b0;
		foreach (rows[k]) begin
			wr(OP_STATUS1_WRITE, {4'h0, rows[k].bp, 2'b00});
			rd1();
			rd_is("s1_guard", {4'h0, rows[k].bp, 2'b00});
			n0 = n_req;
			set_write_latch_cmd();
			xfer({rows[k].cmd, rows[k].addr, 16'hA500},
				rows[k].cmd == OP_PROGRAM ? 32 : rows[k].cmd == OP_PAGE_ERASE ? 24 : 8);
			check("mem_req", 16'(n_req - n0), 16'(rows[k].ok));
			if (rows[k].ok && rows[k].addr !== 16'h0000) check("mem_addr", mem_addr, rows[k].addr);
			wait_idle();
		end
		guard_n = 1'b1;
		check("osc_full", 16'(osc_seen), 16'h0);
		// status2 write: reserved bits drop, busy, then latch and busy clear
		set_write_latch_cmd();
		xfer({OP_STATUS2_WRITE, 8'hFE, 24'h0}, 16);
		rd1();
		rd_is("s2_busy", 8'h07);
		wait_idle();
		rd_is("s2_done", 8'h04);
		xfer({OP_STATUS2_READ, 32'h0}, 16);
		rd_is("s2_value", 8'h02);
		set_write_latch_cmd();
		xfer({OP_PROGRAM, 16'h1234, 16'h5A00}, 32);
		wait_idle();
		check("osc_slow", 16'(osc_seen), 16'h1);
		check("mem_data", 16'(mem_data), 16'h005A);
		// auto deep sleep follows a program, not the status2 write itself
		wr(OP_STATUS2_WRITE, 8'h01);
		pwr("no_auto_deep", PWR_STANDBY);
		set_write_latch_cmd();
		xfer({OP_PROGRAM, 16'h2000, 16'h1100}, 32);
		repeat (240) @(negedge clk);
		pwr("auto_deep", PWR_DEEP_SLEEP);
		rd1();
		rd_is("deep_flag", 8'hFF);
		n0 = n_req;
		set_write_latch_cmd();
		xfer({OP_PROGRAM, 16'h2000, 16'h1100}, 32);
		xfer({OP_WAKE, 32'h0}, 8);
		check("deep_ignores", 16'(n_req - n0), 16'h0);
		pwr("deep_stays", PWR_DEEP_SLEEP);
		deep_exit = 1'b1;
		repeat (8) @(negedge clk);
		deep_exit = 1'b0;
		repeat (8) @(negedge clk);
		pwr("deep_exit", PWR_STANDBY);
		wr(OP_STATUS2_WRITE, 8'h00);
		// sleep command under each idle mode
		for (int m = 0; m < 3; m++) begin
			wr(OP_STATUS1_WRITE, cfg[m]);
			pwr("idle_mode", idle[m]);
			rd1();
			rd_is("idle_cmds", cfg[m]);
			set_write_latch_cmd();
			xfer({OP_SLEEP, 32'h0}, 8);
			pwr("sleep", PWR_SLEEP);
			n0 = n_req;
			set_write_latch_cmd();
			xfer({OP_PROGRAM, 16'h0100, 16'h2200}, 32);
			rd1();
			rd_is("sleep_read", 8'hFF);
			check("sleep_ignores", 16'(n_req - n0), 16'h0);
			xfer({OP_WAKE, 32'h0}, 8);
			pwr("wake", idle[m]);
			rd1();
			rd_is("sleep_latch", cfg[m]);
		end
		// lock bit against the guard pin
		wr(OP_STATUS1_WRITE, 8'h80);
		guard_n = 1'b0;
		wr(OP_STATUS1_WRITE, 8'h00);
		rd1();
		rd_is("lock_held", 8'h80);
		guard_n = 1'b1;
		wr(OP_STATUS1_WRITE, 8'h00);
		rd1();
		rd_is("lock_clear", 8'h00);
		summarize();
	end
endmodule : epc_guard_power_tb_top
`default_nettype wire
